// ---- job_request_validator.sv ----
`timescale 1ns/1ps

// How it works
// - every job acknowledged; 0x80 means accepted
// - unknown job code rejected with 0x81
// - bad first header 0x82, later 0x83
// - init-only job in run phase gives 0x84
// - after-init job during init gives 0x86
// - reset-only state rejects others with 0x85
// - reset job 40 wrong length gives 0x8A
// - job 02 checks length through mains, 0x90-0x95
// - job 03 length 0x9A, test setting 0x9B
// - jobs 04/05/06 length then channel errors
// - setpoint above full scale rejected
// - half-percent setpoint needs capable pulsing mode
// - job 07 field, type, channel checked
// - field types 0/1 need ordered channels
// - job 08 length 0xCA, field 0xCB
// - standby factor host codes A0DA, A0DB
// - channel diagnosis host codes A0BA, A0BB
// - field diagnosis host codes A0D0, A0D1, A0D2
// - host code A000 while job processing
module job_request_validator (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic JOB_VALID,
    input wire job_validator_pkg::job_s JOB,
    input wire logic LOCK_PIN,
    output logic JOB_READY,
    output logic ACK_VALID,
    output job_validator_pkg::ack_s ACK,
    output logic [15:0] HOST_CODE,
    output logic APPLY_VALID,
    output job_validator_pkg::job_s APPLY_JOB,
    output logic PHASE_LOCK,
    output logic PHASE_INIT,
    output logic PHASE_RUN
);

    // ****************************************
    // check helpers
    // ****************************************
    function automatic logic chan_ok(input logic [7:0] ch);
        chan_ok = (ch != 8'h00) && (ch <= job_validator_pkg::MAX_CHANNEL);
    endfunction

    function automatic logic field_ok(input logic [7:0] fld);
        field_ok = (fld != 8'h00) && (fld <= job_validator_pkg::MAX_FIELD);
    endfunction

    function automatic logic is_known(input logic [7:0] code);
        case (code)
            job_validator_pkg::JOB_SETUP_A,
            job_validator_pkg::JOB_SETUP_B,
            job_validator_pkg::JOB_SETPT_1,
            job_validator_pkg::JOB_SETPT_2,
            job_validator_pkg::JOB_SETPT_START,
            job_validator_pkg::JOB_FIELD_DEF,
            job_validator_pkg::JOB_FACTOR_PROD,
            job_validator_pkg::JOB_FACTOR_STBY,
            job_validator_pkg::JOB_DIAG_CHAN,
            job_validator_pkg::JOB_DIAG_FIELD,
            job_validator_pkg::JOB_RESET: is_known = 1'b1;
            default: is_known = 1'b0;
        endcase
    endfunction

    function automatic logic is_init_only(input logic [7:0] code);
        is_init_only = (code == job_validator_pkg::JOB_SETUP_A) ||
                       (code == job_validator_pkg::JOB_SETUP_B) ||
                       (code == job_validator_pkg::JOB_FIELD_DEF);
    endfunction

    function automatic logic hdr_ok(input job_validator_pkg::job_s j);
        hdr_ok = (j.hdr_first == job_validator_pkg::FRAME_HEADER) &&
                 (!j.multi || (j.hdr_next == job_validator_pkg::FRAME_HEADER));
    endfunction

    // shared checks of the three setpoint jobs, offsets from the group base
    function automatic logic [7:0] check_setpt(input job_validator_pkg::job_s j,
                                               input logic [7:0] base,
                                               input logic half_ok);
        if (j.length != job_validator_pkg::LEN_SETPT) begin
            check_setpt = base;
        end else if (!chan_ok(j.p0)) begin
            check_setpt = base + 8'h01;
        end else if (j.p1[0] && !half_ok) begin
            check_setpt = base + 8'h02;
        end else if (j.p1 > job_validator_pkg::SETPT_FULL) begin
            check_setpt = base + 8'h03;
        end else begin
            check_setpt = job_validator_pkg::ST_OK;
        end
    endfunction

    // the if-chain is the check order: the first failure wins
    function automatic logic [7:0] check_job(input job_validator_pkg::job_s j,
                                             input job_validator_pkg::phase_e ph,
                                             input logic half_ok);
        check_job = job_validator_pkg::ST_OK;
        if (!is_known(j.code)) begin
            check_job = job_validator_pkg::ST_BAD_CODE;
        end else if (j.hdr_first != job_validator_pkg::FRAME_HEADER) begin
            check_job = job_validator_pkg::ST_HDR_FIRST;
        end else if (!hdr_ok(j)) begin
            check_job = job_validator_pkg::ST_HDR_NEXT;
        end else if (ph == job_validator_pkg::PH_LOCK &&
                     j.code != job_validator_pkg::JOB_RESET) begin
            check_job = job_validator_pkg::ST_RESET_ONLY;
        end else if (is_init_only(j.code) && ph != job_validator_pkg::PH_INIT) begin
            check_job = job_validator_pkg::ST_INIT_ONLY;
        end else if (!is_init_only(j.code) && j.code != job_validator_pkg::JOB_RESET &&
                     ph != job_validator_pkg::PH_RUN) begin
            check_job = job_validator_pkg::ST_AFTER_INIT;
        end else begin
            case (j.code)
                job_validator_pkg::JOB_RESET: begin
                    if (j.length != job_validator_pkg::LEN_RESET) begin
                        check_job = job_validator_pkg::ST_RESET_LEN;
                    end
                end
                job_validator_pkg::JOB_SETUP_A: begin
                    if (j.length != job_validator_pkg::LEN_SETUP_A) begin
                        check_job = job_validator_pkg::ST_SETUP_A_BASE;
                    end else if (!chan_ok(j.p0)) begin
                        check_job = job_validator_pkg::ST_SETUP_A_BASE + 8'h01;
                    end else if (j.p1 > job_validator_pkg::MAX_SUBST) begin
                        check_job = job_validator_pkg::ST_SETUP_A_BASE + 8'h02;
                    end else if (j.p2 > job_validator_pkg::MAX_PULSE_MODE) begin
                        check_job = job_validator_pkg::ST_SETUP_A_BASE + 8'h03;
                    end else if (j.p3 > job_validator_pkg::MAX_REPEAT_DIAG) begin
                        check_job = job_validator_pkg::ST_SETUP_A_BASE + 8'h04;
                    end else if (j.p4 > job_validator_pkg::MAX_MAINS) begin
                        check_job = job_validator_pkg::ST_SETUP_A_BASE + 8'h05;
                    end
                end
                job_validator_pkg::JOB_SETUP_B: begin
                    if (j.length != job_validator_pkg::LEN_SETUP_B) begin
                        check_job = job_validator_pkg::ST_SETUP_B_BASE;
                    end else if (j.p0 > job_validator_pkg::MAX_TEST) begin
                        check_job = job_validator_pkg::ST_SETUP_B_BASE + 8'h01;
                    end
                end
                job_validator_pkg::JOB_SETPT_1: begin
                    check_job = check_setpt(j, job_validator_pkg::ST_SETPT_1_BASE, half_ok);
                end
                job_validator_pkg::JOB_SETPT_2: begin
                    check_job = check_setpt(j, job_validator_pkg::ST_SETPT_2_BASE, half_ok);
                end
                job_validator_pkg::JOB_SETPT_START: begin
                    check_job = check_setpt(j, job_validator_pkg::ST_SETPT_S_BASE, half_ok);
                end
                job_validator_pkg::JOB_FIELD_DEF: begin
                    if (!field_ok(j.p0)) begin
                        check_job = job_validator_pkg::ST_FIELD_BASE;
                    end else if (j.p1 > job_validator_pkg::MAX_FIELD_TYPE) begin
                        check_job = job_validator_pkg::ST_FIELD_BASE + 8'h01;
                    end else if (!chan_ok(j.p2) || !chan_ok(j.p3)) begin
                        check_job = job_validator_pkg::ST_FIELD_BASE + 8'h02;
                    end else if (j.p1 <= 8'h01 && j.p2 > j.p3) begin
                        check_job = job_validator_pkg::ST_FIELD_BASE + 8'h03;
                    end
                end
                job_validator_pkg::JOB_FACTOR_PROD: begin
                    if (j.length != job_validator_pkg::LEN_FACTOR) begin
                        check_job = job_validator_pkg::ST_PROD_BASE;
                    end else if (!field_ok(j.p0)) begin
                        check_job = job_validator_pkg::ST_PROD_BASE + 8'h01;
                    end
                end
                job_validator_pkg::JOB_FACTOR_STBY: begin
                    if (j.length != job_validator_pkg::LEN_FACTOR) begin
                        check_job = job_validator_pkg::ST_STBY_BASE;
                    end else if (!field_ok(j.p0)) begin
                        check_job = job_validator_pkg::ST_STBY_BASE + 8'h01;
                    end
                end
                job_validator_pkg::JOB_DIAG_CHAN: begin
                    if (j.length != job_validator_pkg::LEN_DIAG) begin
                        check_job = job_validator_pkg::ST_DCHAN_BASE;
                    end else if (j.p1 > job_validator_pkg::MAX_DIAG_TYPE) begin
                        check_job = job_validator_pkg::ST_DCHAN_BASE + 8'h01;
                    end
                end
                job_validator_pkg::JOB_DIAG_FIELD: begin
                    if (j.length != job_validator_pkg::LEN_DIAG) begin
                        check_job = job_validator_pkg::ST_DFIELD_BASE;
                    end else if (!field_ok(j.p0)) begin
                        check_job = job_validator_pkg::ST_DFIELD_BASE + 8'h01;
                    end else if (j.p1 > job_validator_pkg::MAX_DIAG_TYPE) begin
                        check_job = job_validator_pkg::ST_DFIELD_BASE + 8'h02;
                    end
                end
                default: begin
                    check_job = job_validator_pkg::ST_BAD_CODE;
                end
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    job_validator_pkg::job_s job_reg;
    job_validator_pkg::phase_e phase_reg;
    logic busy_reg;
    logic [7:0] pulse_mode_reg;
    logic lock_level;
    logic lock_prev_reg;
    logic lock_event;
    logic half_ok;
    logic take;
    logic [7:0] status_next;
    logic accepted;

    input_sync lock_sync (
        .clk(CLK),
        .srst(SRST),
        .pin(LOCK_PIN),
        .level(lock_level)
    );

    assign take = JOB_VALID && JOB_READY;
    assign half_ok = (pulse_mode_reg == job_validator_pkg::PULSE_HALF_OK);
    assign status_next = check_job(job_reg, phase_reg, half_ok);
    assign accepted = busy_reg && (status_next == job_validator_pkg::ST_OK);
    assign lock_event = lock_level && !lock_prev_reg;

    // ****************************************
    // job intake and acknowledgement
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            busy_reg <= 1'b0;
            JOB_READY <= 1'b0;
            job_reg <= '0;
        end else if (take) begin
            busy_reg <= 1'b1;
            JOB_READY <= 1'b0;
            job_reg <= JOB;
        end else begin
            busy_reg <= 1'b0;
            JOB_READY <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ACK_VALID <= 1'b0;
            ACK <= '0;
            HOST_CODE <= 16'h0000;
        end else if (busy_reg) begin
            ACK_VALID <= 1'b1;
            ACK.status <= status_next;
            ACK.host_code <= {job_validator_pkg::HOST_HIGH, status_next};
            HOST_CODE <= {job_validator_pkg::HOST_HIGH, status_next};
        end else begin
            ACK_VALID <= 1'b0;
            if (take) begin
                HOST_CODE <= job_validator_pkg::HOST_BUSY;
            end
        end
    end

    // rejected jobs never reach the channel logic
    always_ff @(posedge CLK) begin
        if (SRST) begin
            APPLY_VALID <= 1'b0;
            APPLY_JOB <= '0;
        end else begin
            APPLY_VALID <= accepted;
            if (accepted) begin
                APPLY_JOB <= job_reg;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pulse_mode_reg <= job_validator_pkg::RST_PULSE_MODE;
        end else if (accepted && job_reg.code == job_validator_pkg::JOB_SETUP_A) begin
            pulse_mode_reg <= job_reg.p2;
        end
    end

    // ****************************************
    // configuration phase
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            lock_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= lock_level;
        end
    end

    // a new lock request wins over a job finishing in the same cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            phase_reg <= job_validator_pkg::PH_INIT;
        end else if (lock_event) begin
            phase_reg <= job_validator_pkg::PH_LOCK;
        end else if (accepted) begin
            case (job_reg.code)
                job_validator_pkg::JOB_RESET: phase_reg <= job_validator_pkg::PH_INIT;
                job_validator_pkg::JOB_SETUP_B: phase_reg <= job_validator_pkg::PH_RUN;
                default: phase_reg <= phase_reg;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            PHASE_LOCK <= 1'b0;
            PHASE_INIT <= 1'b0;
            PHASE_RUN <= 1'b0;
        end else begin
            PHASE_LOCK <= (phase_reg == job_validator_pkg::PH_LOCK);
            PHASE_INIT <= (phase_reg == job_validator_pkg::PH_INIT);
            PHASE_RUN <= (phase_reg == job_validator_pkg::PH_RUN);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_take;
        JOB_VALID && JOB_READY;
    endsequence

    sequence s_busy_then_ack;
        HOST_CODE == job_validator_pkg::HOST_BUSY && !ACK_VALID ##1 ACK_VALID;
    endsequence

    a_ack_every_job: assert property (s_take |=> s_busy_then_ack)
        else $error("job taken without busy code and acknowledgement");

    a_host_code_form: assert property (ACK_VALID |->
        HOST_CODE == {8'hA0, ACK.status} && ACK.host_code == HOST_CODE)
        else $error("host code does not carry the status byte");

    a_reject_no_apply: assert property (ACK_VALID && ACK.status != 8'h80 |-> !APPLY_VALID)
        else $error("rejected job was applied");

    a_apply_on_ok: assert property (ACK_VALID && ACK.status == 8'h80 |-> APPLY_VALID)
        else $error("accepted job not applied");

    a_unknown_code: assert property (busy_reg && !is_known(job_reg.code) |=>
        ACK.status == 8'h81)
        else $error("unknown code not answered 0x81");

    a_first_header: assert property (busy_reg && is_known(job_reg.code) &&
        job_reg.hdr_first != job_validator_pkg::FRAME_HEADER |=> ACK.status == 8'h82)
        else $error("bad first header not answered 0x82");

    a_lock_only_reset: assert property (busy_reg && hdr_ok(job_reg) &&
        is_known(job_reg.code) && phase_reg == job_validator_pkg::PH_LOCK &&
        job_reg.code != 8'h28 |=> ACK.status == 8'h85)
        else $error("locked phase did not answer 0x85");

    a_init_only_job: assert property (busy_reg && hdr_ok(job_reg) &&
        job_reg.code == 8'h02 && phase_reg == job_validator_pkg::PH_RUN |=>
        ACK.status == 8'h84)
        else $error("init-only job outside init not answered 0x84");

    a_after_init_job: assert property (busy_reg && hdr_ok(job_reg) &&
        job_reg.code == 8'h04 && phase_reg == job_validator_pkg::PH_INIT |=>
        ACK.status == 8'h86)
        else $error("run-only job during init not answered 0x86");

    a_setpoint_full: assert property (busy_reg && hdr_ok(job_reg) &&
        job_reg.code == 8'h05 && phase_reg == job_validator_pkg::PH_RUN &&
        job_reg.length == 8'h04 && chan_ok(job_reg.p0) && !job_reg.p1[0] &&
        job_reg.p1 > 8'hC8 |=> ACK.status == 8'hAD)
        else $error("setpoint above full scale not answered 0xAD");

endmodule

// ---- job_validator_pkg.sv ----
package job_validator_pkg;

    // ****************************************
    // job codes
    // ****************************************
    localparam logic [7:0] JOB_SETUP_A = 8'h02;
    localparam logic [7:0] JOB_SETUP_B = 8'h03;
    localparam logic [7:0] JOB_SETPT_1 = 8'h04;
    localparam logic [7:0] JOB_SETPT_2 = 8'h05;
    localparam logic [7:0] JOB_SETPT_START = 8'h06;
    localparam logic [7:0] JOB_FIELD_DEF = 8'h07;
    localparam logic [7:0] JOB_FACTOR_PROD = 8'h08;
    localparam logic [7:0] JOB_FACTOR_STBY = 8'h09;
    localparam logic [7:0] JOB_DIAG_CHAN = 8'h0A;
    localparam logic [7:0] JOB_DIAG_FIELD = 8'h0B;
    localparam logic [7:0] JOB_RESET = 8'h28;

    // ****************************************
    // expected lengths and limits
    // ****************************************
    localparam logic [7:0] LEN_RESET = 8'h02;
    localparam logic [7:0] LEN_SETUP_A = 8'h08;
    localparam logic [7:0] LEN_SETUP_B = 8'h04;
    localparam logic [7:0] LEN_SETPT = 8'h04;
    localparam logic [7:0] LEN_FACTOR = 8'h04;
    localparam logic [7:0] LEN_DIAG = 8'h04;
    localparam logic [7:0] FRAME_HEADER = 8'hA5;
    localparam logic [7:0] MAX_CHANNEL = 8'h30;
    localparam logic [7:0] MAX_FIELD = 8'h10;
    localparam logic [7:0] MAX_SUBST = 8'h02;
    localparam logic [7:0] MAX_PULSE_MODE = 8'h03;
    localparam logic [7:0] PULSE_HALF_OK = 8'h01;
    localparam logic [7:0] MAX_REPEAT_DIAG = 8'h0A;
    localparam logic [7:0] MAX_MAINS = 8'h02;
    localparam logic [7:0] MAX_TEST = 8'h01;
    localparam logic [7:0] MAX_FIELD_TYPE = 8'h02;
    localparam logic [7:0] MAX_DIAG_TYPE = 8'h03;
    localparam logic [7:0] SETPT_FULL = 8'hC8;
    localparam logic [7:0] RST_PULSE_MODE = 8'h00;

    // ****************************************
    // status codes
    // ****************************************
    localparam logic [7:0] ST_OK = 8'h80;
    localparam logic [7:0] ST_BAD_CODE = 8'h81;
    localparam logic [7:0] ST_HDR_FIRST = 8'h82;
    localparam logic [7:0] ST_HDR_NEXT = 8'h83;
    localparam logic [7:0] ST_INIT_ONLY = 8'h84;
    localparam logic [7:0] ST_RESET_ONLY = 8'h85;
    localparam logic [7:0] ST_AFTER_INIT = 8'h86;
    localparam logic [7:0] ST_RESET_LEN = 8'h8A;
    localparam logic [7:0] ST_SETUP_A_BASE = 8'h90;
    localparam logic [7:0] ST_SETUP_B_BASE = 8'h9A;
    localparam logic [7:0] ST_SETPT_1_BASE = 8'hA0;
    localparam logic [7:0] ST_SETPT_2_BASE = 8'hAA;
    localparam logic [7:0] ST_SETPT_S_BASE = 8'hB0;
    localparam logic [7:0] ST_FIELD_BASE = 8'hC0;
    localparam logic [7:0] ST_PROD_BASE = 8'hCA;
    localparam logic [7:0] ST_STBY_BASE = 8'hDA;
    localparam logic [7:0] ST_DCHAN_BASE = 8'hBA;
    localparam logic [7:0] ST_DFIELD_BASE = 8'hD0;
    localparam logic [7:0] HOST_HIGH = 8'hA0;
    localparam logic [15:0] HOST_BUSY = 16'hA000;

    typedef enum {PH_LOCK, PH_INIT, PH_RUN} phase_e;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] length;
        logic [7:0] hdr_first;
        logic [7:0] hdr_next;
        logic multi;
        logic [7:0] p0;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
    } job_s;

    typedef struct packed {
        logic [7:0] status;
        logic [15:0] host_code;
    } ack_s;

endpackage

// ---- input_sync.sv ----
`timescale 1ns/1ps

// ****************************************
// three-stage pin synchroniser
// ****************************************
module input_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    output logic level
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once two settled stages agree
    always_ff @(posedge clk) begin
        if (srst) begin
            level <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level <= s3_reg;
        end
    end

endmodule

// ---- job_master.sv ----
`timescale 1ns/1ps

// ****************************************
// fieldbus master: one job at a time
// ****************************************
module job_master (
    input wire logic CLK,
    input wire logic JOB_READY,
    output logic JOB_VALID,
    output job_validator_pkg::job_s JOB
);
    initial begin
        JOB_VALID = 1'b0;
        JOB = '0;
    end

    // held until taken; released data is scrambled so stale values never pass
    task automatic send(input job_validator_pkg::job_s j);
        @(posedge CLK);
        JOB_VALID <= 1'b1;
        JOB <= j;
        do @(posedge CLK); while (JOB_READY !== 1'b1);
        JOB_VALID <= 1'b0;
        JOB <= ~j;
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps

// ****************************************
// job validator bench
// ****************************************
module testbench;
    logic CLK, SRST, LOCK_PIN, JOB_VALID, JOB_READY, ACK_VALID, APPLY_VALID;
    logic PHASE_LOCK, PHASE_INIT, PHASE_RUN;
    logic [15:0] HOST_CODE;
    job_validator_pkg::job_s JOB, APPLY_JOB;
    job_validator_pkg::ack_s ACK;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    job_master u_master (.CLK(CLK), .JOB_READY(JOB_READY), .JOB_VALID(JOB_VALID), .JOB(JOB));
    job_request_validator u_dut (.CLK(CLK), .SRST(SRST), .JOB_VALID(JOB_VALID), .JOB(JOB),
        .LOCK_PIN(LOCK_PIN), .JOB_READY(JOB_READY), .ACK_VALID(ACK_VALID), .ACK(ACK),
        .HOST_CODE(HOST_CODE), .APPLY_VALID(APPLY_VALID), .APPLY_JOB(APPLY_JOB),
        .PHASE_LOCK(PHASE_LOCK), .PHASE_INIT(PHASE_INIT), .PHASE_RUN(PHASE_RUN));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic wrap_up;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 1500) begin
            num_errors++;
            wrap_up;
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic job_validator_pkg::job_s mk(input logic [55:0] v);
        mk = '{code: v[55:48], length: v[47:40], hdr_first: 8'hA5, hdr_next: 8'hA5, multi: 1'b0,
            p0: v[39:32], p1: v[31:24], p2: v[23:16], p3: v[15:8], p4: v[7:0]};
    endfunction

    function automatic logic [7:0] sbase(input int i);
        sbase = (i == 0) ? 8'hA0 : (i == 1) ? 8'hAA : 8'hB0;
    endfunction

    task automatic run(input job_validator_pkg::job_s j, input logic [7:0] st);
        u_master.send(j);
        #1;
        chk(HOST_CODE, 16'hA000);
        @(posedge CLK);
        #1;
        chk({15'h0000, ACK_VALID}, 16'h0001);
        chk(ACK.host_code, {8'hA0, st});
        chk(HOST_CODE, {8'hA0, st});
        chk({7'h00, APPLY_VALID, ACK.status}, {7'h00, st == 8'h80, st});
        if (st == 8'h80) chk({15'h0000, APPLY_JOB === j}, 16'h0001);
    endtask

    task automatic ph(input logic [2:0] e);
        @(posedge CLK);
        #1;
        chk({13'h0000, PHASE_LOCK, PHASE_INIT, PHASE_RUN}, {13'h0000, e});
    endtask

    task automatic t_init;
        job_validator_pkg::job_s j;
        run(mk(56'h04_04_01_00_00_00_00), 8'h86);
        j = mk(56'h01_04_01_00_00_00_00);
        j.hdr_first = 8'h00;
        run(j, 8'h81);
        j = mk(56'h28_02_00_00_00_00_00);
        j.hdr_first = 8'h5A;
        run(j, 8'h82);
        j.hdr_first = 8'hA5;
        j.multi = 1'b1;
        j.hdr_next = 8'h00;
        run(j, 8'h83);
        run(mk(56'h28_03_00_00_00_00_00), 8'h8A);
        run(mk(56'h28_02_00_00_00_00_00), 8'h80);
        $display("t_init done");
    endtask

    task automatic t_setup;
        logic [63:0] t[18] = '{64'h02_07_00_09_00_00_00_90, 64'h02_08_31_00_00_00_00_91,
            64'h02_08_01_03_00_00_00_92, 64'h02_08_01_02_04_00_00_93,
            64'h02_08_01_02_03_0B_00_94, 64'h02_08_01_02_03_0A_03_95,
            64'h02_08_30_02_01_0A_02_80, 64'h07_00_11_00_01_01_00_C0,
            64'h07_00_10_03_01_01_00_C1, 64'h07_00_01_02_31_01_00_C2,
            64'h07_00_01_01_05_04_00_C3, 64'h07_00_01_00_05_04_00_C3,
            64'h07_00_01_02_05_04_00_80, 64'h03_05_01_00_00_00_00_9A,
            64'h03_04_02_00_00_00_00_9B, 64'h03_04_01_00_00_00_00_80,
            64'h02_08_01_00_00_00_00_84, 64'h07_00_01_02_01_01_00_84};
        foreach (t[i]) run(mk(t[i][63:8]), t[i][7:0]);
        ph(3'b001);
        $display("t_setup done");
    endtask

    task automatic t_run;
        logic [7:0] c;
        logic [39:0] t[9] = '{40'h08_05_01_00_CA, 40'h08_04_11_00_CB, 40'h09_03_01_00_DA,
            40'h09_04_00_00_DB, 40'h0A_05_01_00_BA, 40'h0A_04_01_04_BB,
            40'h0B_05_01_00_D0, 40'h0B_04_11_00_D1, 40'h0B_04_01_04_D2};
        for (int i = 0; i < 3; i++) begin
            c = 8'h04 + 8'(i);
            run(mk({c, 48'h05_01_00_00_00_00}), sbase(i));
            run(mk({c, 48'h04_31_00_00_00_00}), sbase(i) + 8'h01);
            run(mk({c, 48'h04_30_CA_00_00_00}), sbase(i) + 8'h03);
            run(mk({c, 48'h04_01_C8_00_00_00}), 8'h80);
        end
        foreach (t[i]) run(mk({t[i][39:8], 24'h000000}), t[i][7:0]);
        $display("t_run done");
    endtask

    task automatic t_lock;
        @(posedge CLK);
        LOCK_PIN <= 1'b1;
        repeat (8) @(posedge CLK);
        ph(3'b100);
        run(mk(56'h04_04_01_00_00_00_00), 8'h85);
        run(mk(56'h28_01_00_00_00_00_00), 8'h8A);
        LOCK_PIN <= 1'b0;
        run(mk(56'h28_02_00_00_00_00_00), 8'h80);
        @(posedge CLK);
        ph(3'b010);
        $display("t_lock done");
    endtask

    task automatic t_half;
        run(mk(56'h02_08_01_00_00_00_00), 8'h80);
        run(mk(56'h03_04_00_00_00_00_00), 8'h80);
        for (int i = 0; i < 3; i++) begin
            run(mk({8'h04 + 8'(i), 48'h04_01_CB_00_00_00}), sbase(i) + 8'h02);
        end
        $display("t_half done");
    endtask

    initial begin
        SRST = 1'b1;
        LOCK_PIN = 1'b0;
        repeat (4) @(posedge CLK);
        SRST <= 1'b0;
        ph(3'b010);
        t_init;
        t_setup;
        t_run;
        t_lock;
        t_half;
        wrap_up;
    end
endmodule
